// [pkg/apdu_pkg.sv]
// Constants for the automatic power-down unit
// What this block does
// - Idle strobe starts four-bit aux-clock counter
// - Fifteen idle aux periods raise power-down
// - Enable, chip-select high and no reset permit entry
// - Strobe pulses end power-down at once
// - Chip-select low or reset ends power-down
// - Power-down blocks bus, deselects memories
// - Counter keeps aux clock despite blocking
// - Pins hold, address undefined, data tri-state
// - Power-down leaves logic arrays unchanged
// - Chip-select high disables memories, io space
// - Chip-select deselect blocks nothing else
// - Host writes power-mode registers; bits block
// - First register bit 3 turns turbo off
// - Aux clock feeds macrocells and counter
// - First register bit 1 enables power-down
// - Registers clear at power-up only
// - Second register bits 2-6 block array inputs
// - Bits 4,5 disconnect aux from array, macrocells
package apdu_pkg;
  localparam int APDU_CNT_W = 4;
  localparam logic [3:0] APDU_IDLE_LIMIT = 4'hf;
  localparam logic [7:0] APDU_PMR_RESET = 8'h00;
  localparam int APDU_R0_APD_EN = 1;
  localparam int APDU_R0_TURBO_OFF = 3;
  localparam int APDU_R0_ARRAY_CLK_OFF = 4;
  localparam int APDU_R0_MCELL_CLK_OFF = 5;
  localparam int APDU_R2_CNTL0 = 2;
  localparam int APDU_R2_STROBE = 5;
  localparam int APDU_R2_DBE = 6;
  localparam int APDU_R2_BLK_N = 5;
  localparam logic [7:0] APDU_R0_USED = 8'h3a;
  localparam logic [7:0] APDU_R2_USED = 8'h7c;
endpackage

// [pkg/apdu_idle_if.sv]
// Link between the power-down controller and its idle counter
`timescale 1ns/100ps
interface apdu_idle_if;
  logic enable;
  logic clear;
  logic aux_rise;
  logic expired;
  modport ctrl (output enable, output clear, output aux_rise, input expired);
  modport cnt (input enable, input clear, input aux_rise, output expired);
endinterface

// [hdl/apdu_idle_counter.sv]
// Four-bit idle counter stepped on auxiliary clock periods
`timescale 1ns/100ps
module apdu_idle_counter
  import apdu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Controller side
  apdu_idle_if.cnt idle
);
  logic [APDU_CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!idle.enable || idle.clear) begin
      cnt_q <= '0;
    end else if (idle.aux_rise && cnt_q != APDU_IDLE_LIMIT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign idle.expired = (cnt_q == APDU_IDLE_LIMIT);

  property p_cnt_clear;
    @(posedge core_clk) disable iff (!rst_n) idle.clear |=> cnt_q == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("idle counter not cleared");
  property p_cnt_step;
    @(posedge core_clk) disable iff (!rst_n)
    (idle.enable && !idle.clear && idle.aux_rise && !idle.expired) |=>
      cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("idle counter did not step");
endmodule

// [hdl/apdu_power_down.sv]
// Automatic power-down controller with power-mode registers and gating
`timescale 1ns/100ps
module apdu_power_down
  import apdu_pkg::*;
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_in,
  // Host pins, asynchronous
  input wire logic address_strobe_in,
  input wire logic aux_clock_in,
  input wire logic chip_select_in,
  // Host bus toward memories and arrays
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_data,
  input wire logic cntl0_in,
  input wire logic cntl1_in,
  input wire logic cntl2_in,
  input wire logic data_byte_enable,
  // Power-mode register writes
  input wire logic pmr_first_we,
  input wire logic pmr_second_we,
  input wire logic [7:0] pmr_wdata,
  // Port functions for pin gating
  input wire logic addr_out_en,
  input wire logic data_port_en,
  input wire logic periph_io_en,
  // Status and register read back
  output logic power_down_flag,
  output logic [7:0] power_mode_reg_first,
  output logic [7:0] power_mode_reg_second,
  // Memory side
  output logic [15:0] mem_addr,
  output logic [7:0] mem_data,
  output logic flash_sel,
  output logic sram_sel,
  output logic io_control_space_sel,
  // Logic array side
  output logic [15:0] array_addr,
  output logic [7:0] array_data,
  output logic array_cntl0,
  output logic array_cntl1,
  output logic array_cntl2,
  output logic array_strobe,
  output logic array_dbe,
  output logic array_aux_clk,
  output logic mcell_aux_clk,
  output logic array_turbo,
  // Pin drivers
  output logic addr_pin_oe,
  output logic data_pin_oe,
  output logic periph_pin_oe
);
  import apdu_pkg::*;

  typedef enum logic {APDU_RUN, APDU_DOWN} apdu_state_t;

  apdu_idle_if idle ();
  apdu_state_t state_q;
  logic [2:0] strobe_sync_q, aux_sync_q, cs_sync_q;
  logic strobe_act, aux_rise, cs_n_lvl, apd_en;
  logic [7:0] pmr0_q, pmr2_q;
  logic rst_sync_q, rst_lvl_q, wake;

  // Two-flop synchronisers plus a third stage for edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_sync_q <= 3'h0;
      aux_sync_q <= 3'h0;
      cs_sync_q <= 3'h7;
      rst_sync_q <= 1'b0;
      rst_lvl_q <= 1'b0;
    end else begin
      strobe_sync_q <= {strobe_sync_q[1:0], address_strobe_in};
      aux_sync_q <= {aux_sync_q[1:0], aux_clock_in};
      cs_sync_q <= {cs_sync_q[1:0], chip_select_in};
      rst_sync_q <= reset_in;
      rst_lvl_q <= rst_sync_q;
    end
  end

  assign strobe_act = strobe_sync_q[2] ^ strobe_sync_q[1];
  assign aux_rise = aux_sync_q[1] & ~aux_sync_q[2];
  assign cs_n_lvl = cs_sync_q[1];
  assign apd_en = pmr0_q[APDU_R0_APD_EN];

  // Power-mode registers, cleared only by power-up reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmr0_q <= APDU_PMR_RESET;
      pmr2_q <= APDU_PMR_RESET;
    end else begin
      if (pmr_first_we) begin
        pmr0_q <= pmr_wdata & APDU_R0_USED;
      end
      if (pmr_second_we) begin
        pmr2_q <= pmr_wdata & APDU_R2_USED;
      end
    end
  end

  assign idle.enable = apd_en;
  assign idle.clear = strobe_act;
  assign idle.aux_rise = aux_rise;

  apdu_idle_counter u_cnt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .idle(idle)
  );

  assign wake = strobe_act || !cs_n_lvl || rst_lvl_q || !apd_en;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= APDU_RUN;
    end else begin
      unique case (state_q)
        APDU_RUN: begin
          if (!wake && idle.expired) begin
            state_q <= APDU_DOWN;
          end
        end
        APDU_DOWN: begin
          if (wake) begin
            state_q <= APDU_RUN;
          end
        end
      endcase
    end
  end

  assign power_down_flag = (state_q == APDU_DOWN);
  assign power_mode_reg_first = pmr0_q;
  assign power_mode_reg_second = pmr2_q;

  // Bus toward memories and arrays; power-down blocks it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= 16'h0000;
      mem_data <= 8'h00;
      array_addr <= 16'h0000;
      array_data <= 8'h00;
    end else if (!power_down_flag) begin
      mem_addr <= host_addr;
      mem_data <= host_data;
      array_addr <= host_addr;
      array_data <= host_data;
    end
  end

  // Memory selects: dropped by power-down or chip-select high
  always_comb begin
    sram_sel = !power_down_flag && !cs_n_lvl;
    flash_sel = sram_sel;
    io_control_space_sel = sram_sel;
  end

  // Array inputs gated only by blocking bits, never by power-down
  always_comb begin
    array_cntl0 = cntl0_in & ~pmr2_q[APDU_R2_CNTL0];
    array_cntl1 = cntl1_in & ~pmr2_q[APDU_R2_CNTL0 + 1];
    array_cntl2 = cntl2_in & ~pmr2_q[APDU_R2_CNTL0 + 2];
    array_strobe = strobe_sync_q[1] & ~pmr2_q[APDU_R2_STROBE];
    array_dbe = data_byte_enable & ~pmr2_q[APDU_R2_DBE];
    array_aux_clk = aux_sync_q[1] & ~pmr0_q[APDU_R0_ARRAY_CLK_OFF];
    mcell_aux_clk = aux_sync_q[1] & ~pmr0_q[APDU_R0_MCELL_CLK_OFF];
    array_turbo = ~pmr0_q[APDU_R0_TURBO_OFF];
  end

  // Pin drivers: data and peripheral float, address left undriven
  always_comb begin
    addr_pin_oe = addr_out_en & ~power_down_flag;
    data_pin_oe = data_port_en & ~power_down_flag;
    periph_pin_oe = periph_io_en & ~power_down_flag;
  end

  property p_enter;
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == APDU_RUN && idle.expired && !wake) |=> power_down_flag;
  endproperty
  a_enter: assert property (p_enter) else $error("no power-down entry");
  property p_no_entry_disabled;
    @(posedge core_clk) disable iff (!rst_n) !apd_en |=> !power_down_flag;
  endproperty
  a_no_entry_disabled: assert property (p_no_entry_disabled) else $error("entry while off");
  property p_wake_strobe;
    @(posedge core_clk) disable iff (!rst_n) (power_down_flag && strobe_act) |=> !power_down_flag;
  endproperty
  a_wake_strobe: assert property (p_wake_strobe) else $error("strobe did not wake");
  property p_wake_cs;
    @(posedge core_clk) disable iff (!rst_n) (power_down_flag && !cs_n_lvl) |=> !power_down_flag;
  endproperty
  a_wake_cs: assert property (p_wake_cs) else $error("chip select did not wake");
  property p_wake_rst;
    @(posedge core_clk) disable iff (!rst_n) (power_down_flag && rst_lvl_q) |=> !power_down_flag;
  endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("reset did not wake");
  property p_desel;
    @(posedge core_clk) disable iff (!rst_n)
    (power_down_flag || cs_n_lvl) |-> !sram_sel && !flash_sel && !io_control_space_sel;
  endproperty
  a_desel: assert property (p_desel) else $error("memory selected");
  property p_hold_bus;
    @(posedge core_clk) disable iff (!rst_n) power_down_flag |=> $stable(mem_addr);
  endproperty
  a_hold_bus: assert property (p_hold_bus) else $error("bus not blocked");
  property p_pmr_keep;
    @(posedge core_clk) disable iff (!rst_n)
    (!pmr_first_we && !pmr_second_we) |=> $stable(pmr0_q) && $stable(pmr2_q);
  endproperty
  a_pmr_keep: assert property (p_pmr_keep) else $error("register changed");
  property p_turbo;
    @(posedge core_clk) disable iff (!rst_n)
    pmr_first_we |=> array_turbo == !$past(pmr_wdata[APDU_R0_TURBO_OFF]);
  endproperty
  a_turbo: assert property (p_turbo) else $error("turbo mismatch");
  c_enter: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(power_down_flag));
  c_exit: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(power_down_flag));
  c_block: cover property (@(posedge core_clk) disable iff (!rst_n) pmr2_q[APDU_R2_DBE]);
endmodule

// [testbench/apdu_host_model.sv]
// Host side model driving address strobe and auxiliary clock pins
`timescale 1ns/100ps
module apdu_host_model (
  // Clock
  input wire logic core_clk,
  // Activity controls
  input wire logic strobe_run,
  input wire logic aux_run,
  // Host pins
  output logic address_strobe_in,
  output logic aux_clock_in
);
  logic [3:0] div_q;
  initial begin
    div_q = 4'h0;
    address_strobe_in = 1'b0;
    aux_clock_in = 1'b0;
  end
  always @(posedge core_clk) begin
    div_q <= div_q + 4'h1;
    // Strobe runs at twice the aux rate, far below fifteen times
    if (strobe_run && div_q[1:0] == 2'h3) address_strobe_in <= ~address_strobe_in;
    // Aux held low outside idle runs
    if (!aux_run) aux_clock_in <= 1'b0;
    else if (div_q[2:0] == 3'h7) aux_clock_in <= ~aux_clock_in;
  end
endmodule

// [testbench/apdu_power_down_tb.sv]
// Self-checking bench for the automatic power-down unit
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module apdu_power_down_tb;
  logic core_clk, rst_n, reset_in, address_strobe_in, aux_clock_in, chip_select_in;
  logic [15:0] host_addr, mem_addr, array_addr, a, e;
  logic [7:0] host_data, pmr_wdata, power_mode_reg_first, power_mode_reg_second, d;
  logic [7:0] mem_data, array_data;
  logic cntl0_in, cntl1_in, cntl2_in, data_byte_enable, pmr_first_we, pmr_second_we;
  logic addr_out_en, data_port_en, periph_io_en, power_down_flag, flash_sel, sram_sel;
  logic io_control_space_sel, array_cntl0, array_cntl1, array_cntl2, array_strobe, array_dbe;
  logic array_aux_clk, mcell_aux_clk, array_turbo, addr_pin_oe, data_pin_oe, periph_pin_oe;
  logic strobe_run, aux_run;
  logic [7:0] pm0;
  int seed = 85010, n_errors = 0, tests_run = 0, sel;
  int sel_q[$];
  logic [15:0] val_q[$];
  string names[11] = '{"flag", "reg_first", "reg_second", "turbo", "selects", "mem_addr",
    "array_addr", "array_inputs", "pin_enables", "aux_clocks", "data_paths"};

  apdu_power_down apdu_power_down_i (.*);
  apdu_host_model apdu_host_model_i (.*);

  always #5 core_clk = ~core_clk;

  function automatic logic [15:0] seen(input int s);
    case (s)
      0: return {15'h0, power_down_flag};
      1: return {8'h0, power_mode_reg_first};
      2: return {8'h0, power_mode_reg_second};
      3: return {15'h0, array_turbo};
      4: return {13'h0, flash_sel, io_control_space_sel, sram_sel};
      5: return mem_addr;
      6: return array_addr;
      7: return {11'h0, array_dbe, array_strobe, array_cntl2, array_cntl1, array_cntl0};
      8: return {13'h0, addr_pin_oe, data_pin_oe, periph_pin_oe};
      9: return {14'h0, array_aux_clk, mcell_aux_clk};
      default: return {mem_data, array_data};
    endcase
  endfunction

  task automatic note(input int s, input logic [15:0] v);
    sel_q.push_back(s);
    val_q.push_back(v);
  endtask

  task automatic wr(input logic sec, input logic [7:0] v);
    @(posedge core_clk);
    pmr_wdata <= v;
    pmr_first_we <= !sec;
    pmr_second_we <= sec;
    if (!sec) pm0 = v;
    @(posedge core_clk);
    pmr_first_we <= 1'b0;
    pmr_second_we <= 1'b0;
    @(posedge core_clk);
  endtask

  // Strobe quiet, then n aux rises, then aux stopped
  task automatic idle(input int n);
    @(posedge core_clk);
    strobe_run <= 1'b0;
    repeat (12) @(posedge core_clk);
    aux_run <= 1'b1;
    repeat (n) @(posedge aux_clock_in);
    repeat (3) @(posedge core_clk);
    note(9, {14'h0, ~pm0[4], ~pm0[5]});
    repeat (9) @(posedge core_clk);
    aux_run <= 1'b0;
  endtask

  task automatic wake();
    for (int i = 0; i < 20 && power_down_flag !== 1'b0; i++) @(posedge core_clk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(negedge core_clk) begin
    while (sel_q.size() > 0) begin
      sel = sel_q.pop_front();
      e = val_q.pop_front();
      `CHK(names[sel], e, seen(sel))
    end
  end

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {reset_in, chip_select_in, pmr_first_we, pmr_second_we, strobe_run, aux_run} = '0;
    {cntl0_in, cntl1_in, cntl2_in, data_byte_enable} = 4'hf;
    {addr_out_en, data_port_en, periph_io_en} = 3'h7;
    host_addr = 16'h0;
    host_data = 8'h0;
    pmr_wdata = 8'h0;
    pm0 = 8'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    note(1, 16'h0);
    note(3, 16'h1);
    repeat (4) begin
      d = $random(seed);
      host_data <= d;
      wr(1'b0, d);
      note(1, {8'h0, d & 8'h3a});
      note(3, {15'h0, ~d[3]});
      wr(1'b1, d);
      note(2, {8'h0, d & 8'h7c});
      note(7, {11'h0, ~d[6], 1'b0, ~d[4:2]});
    end
    host_addr <= $random(seed);
    repeat (3) @(posedge core_clk);
    note(4, 16'h7);
    chip_select_in <= 1'b1;
    wr(1'b1, 8'h00);
    repeat (2) @(posedge core_clk);
    note(4, 16'h0);
    note(6, host_addr);
    note(7, 16'h17);
    wr(1'b0, 8'h02);
    idle(14);
    note(0, 16'h0);
    strobe_run <= 1'b1;
    repeat (16) @(posedge core_clk);
    idle(14);
    note(0, 16'h0);
    idle(1);
    note(0, 16'h1);
    note(8, 16'h0);
    note(3, 16'h1);
    a = host_addr;
    host_addr <= $random(seed);
    host_data <= ~d;
    repeat (3) @(posedge core_clk);
    note(5, a);
    note(6, a);
    note(10, {d, d});
    strobe_run <= 1'b1;
    wake();
    note(0, 16'h0);
    note(8, 16'h7);
    idle(15);
    note(0, 16'h1);
    chip_select_in <= 1'b0;
    wake();
    note(0, 16'h0);
    chip_select_in <= 1'b1;
    wr(1'b0, 8'h00);
    idle(15);
    note(0, 16'h0);
    wr(1'b0, 8'h32);
    idle(15);
    note(0, 16'h1);
    reset_in <= 1'b1;
    wake();
    note(0, 16'h0);
    note(1, 16'h32);
    @(posedge core_clk);
    reset_in <= 1'b0;
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    note(1, 16'h0);
    repeat (2) @(posedge core_clk);
    end_of_test();
  end
endmodule
